// file: hw/sfdp_reader.sv
// Serial link front end that answers the discoverable parameter read command.
`timescale 1ns/10ps
`include "sfdp_params.svh"

module sfdp_reader #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Serial link pins, mode 0, most significant bit first
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic si,
  output logic      so,
  output logic      so_oe,
  // Frame status
  output logic      table_busy,
  output logic      cmd_reject
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------

  // The link pins are asynchronous to clk. Each passes two flip-flops and a
  // third delay stage; the last two stages are looked at for the serial clock, the second alone for the others. Because edges are found by sampling,
  // the serial clock must stay well below a quarter of clk; around 6 MHz is
  // a safe ceiling at the 50 MHz core rate.
  logic [2:0] pin_raw;
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic [2:0] pin_prev_r;

  assign pin_raw = {cs_n, sclk, si};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // First stage feeds the second stage and nothing else.
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          pin_meta_r[gi] <= (gi == 2) ? 1'b1 : 1'b0;
          pin_sync_r[gi] <= (gi == 2) ? 1'b1 : 1'b0;
          pin_prev_r[gi] <= (gi == 2) ? 1'b1 : 1'b0;
        end else begin
          pin_meta_r[gi] <= pin_raw[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
          pin_prev_r[gi] <= pin_sync_r[gi];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------

  // Edges are taken between the synchronised sample and its delayed copy.
  logic cs_low;
  logic sclk_rise;
  logic sclk_fall;
  logic si_bit;

  assign cs_low    = ~pin_sync_r[2];
  assign sclk_rise = pin_sync_r[1] & ~pin_prev_r[1];
  assign sclk_fall = ~pin_sync_r[1] & pin_prev_r[1];
  assign si_bit    = pin_sync_r[0];

  // --------------------------------------------------------------------------
  // Frame state
  // --------------------------------------------------------------------------

  sfdp_pkg::phase_t phase_r;
  logic [4:0]       bit_cnt_r;
  logic [7:0]       rx_r;
  logic [23:0]      addr_r;
  logic [7:0]       tx_r;
  logic [7:0]       rom_byte;
  logic [7:0]       rx_full;
  logic             tx_load;

  // Byte as it will stand once the bit sampled on this edge is shifted in.
  assign rx_full = {rx_r[6:0], si_bit};

  // Table lookup at the pointer of the next byte to send. The table is a
  // constant, so nothing the host clocks in can change what it holds.
  sfdp_basic_table_rom u_rom (
    .addr (addr_r),
    .data (rom_byte)
  );

  // Phase sequencing runs on rising serial clock edges while the chip
  // select is low. Raising chip select at any point ends the frame, which
  // is the only way a read ends; the pointer simply keeps counting.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= sfdp_pkg::PH_CMD;
    end else if (!cs_low) begin
      phase_r <= sfdp_pkg::PH_CMD;
    end else if (sclk_rise) begin
      case (phase_r)
        sfdp_pkg::PH_CMD: begin
          if (bit_cnt_r == 5'(`SFDP_BYTE_BITS - 1)) begin
            if (rx_full == `SFDP_READ_OPCODE) begin
              phase_r <= sfdp_pkg::PH_ADDR;
            end else begin
              phase_r <= sfdp_pkg::PH_IGNORE;
            end
          end
        end
        sfdp_pkg::PH_ADDR: begin
          if (bit_cnt_r == 5'(`SFDP_ADDR_BITS - 1)) begin
            phase_r <= sfdp_pkg::PH_DUMMY;
          end
        end
        sfdp_pkg::PH_DUMMY: begin
          if (bit_cnt_r == 5'(`SFDP_DUMMY_CLKS - 1)) begin
            phase_r <= sfdp_pkg::PH_DATA;
          end
        end
        sfdp_pkg::PH_DATA: begin
          phase_r <= sfdp_pkg::PH_DATA;
        end
        sfdp_pkg::PH_IGNORE: begin
          phase_r <= sfdp_pkg::PH_IGNORE;
        end
        default: begin
          phase_r <= sfdp_pkg::PH_IGNORE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Bit counting
  // --------------------------------------------------------------------------

  // Inbound phases count rising edges; the data phase counts falling edges,
  // because that is when each outbound bit is launched.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_r <= 5'h00;
    end else if (!cs_low) begin
      bit_cnt_r <= 5'h00;
    end else if (phase_r == sfdp_pkg::PH_DATA) begin
      if (sclk_fall) begin
        bit_cnt_r <= (bit_cnt_r == 5'(`SFDP_BYTE_BITS - 1)) ? 5'h00 : bit_cnt_r + 5'h01;
      end
    end else if (sclk_rise) begin
      case (phase_r)
        sfdp_pkg::PH_CMD: begin
          bit_cnt_r <= (bit_cnt_r == 5'(`SFDP_BYTE_BITS - 1)) ? 5'h00 : bit_cnt_r + 5'h01;
        end
        sfdp_pkg::PH_ADDR: begin
          bit_cnt_r <= (bit_cnt_r == 5'(`SFDP_ADDR_BITS - 1)) ? 5'h00 : bit_cnt_r + 5'h01;
        end
        sfdp_pkg::PH_DUMMY: begin
          bit_cnt_r <= (bit_cnt_r == 5'(`SFDP_DUMMY_CLKS - 1)) ? 5'h00 : bit_cnt_r + 5'h01;
        end
        default: begin
          bit_cnt_r <= bit_cnt_r;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Command capture
  // --------------------------------------------------------------------------

  // The opcode shifts in most significant bit first on rising edges.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_r <= 8'h00;
    end else if (!cs_low) begin
      rx_r <= 8'h00;
    end else if (sclk_rise && phase_r == sfdp_pkg::PH_CMD) begin
      rx_r <= rx_full;
    end
  end

  // --------------------------------------------------------------------------
  // Table pointer
  // --------------------------------------------------------------------------

  // The three address bytes shift straight into the pointer. Each time a
  // byte is taken for sending the pointer steps up by one, so the bytes of
  // a dword leave least significant first.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= 24'h000000;
    end else if (cs_low) begin
      if (sclk_rise && phase_r == sfdp_pkg::PH_ADDR) begin
        addr_r <= {addr_r[22:0], si_bit};
      end else if (tx_load) begin
        addr_r <= addr_r + 24'h000001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outbound byte
  // --------------------------------------------------------------------------

  // A byte is loaded on the last dummy edge and then after each eighth bit.
  // Loading early keeps the lookup off the path to the pin.
  assign tx_load = (sclk_rise && phase_r == sfdp_pkg::PH_DUMMY &&
                    bit_cnt_r == 5'(`SFDP_DUMMY_CLKS - 1)) ||
                   (sclk_fall && phase_r == sfdp_pkg::PH_DATA &&
                    bit_cnt_r == 5'(`SFDP_BYTE_BITS - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_r <= 8'h00;
    end else if (!cs_low) begin
      tx_r <= 8'h00;
    end else if (tx_load) begin
      tx_r <= rom_byte;
    end else if (sclk_fall && phase_r == sfdp_pkg::PH_DATA) begin
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------

  // Each bit is launched on a falling edge so the host samples it on the
  // next rising edge. The reload on the eighth fall lands after the last
  // bit of the old byte has been taken, so the pin always reads tx_r[7].
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      so <= 1'b1;
    end else if (!cs_low) begin
      so <= 1'b1;
    end else if (sclk_fall && phase_r == sfdp_pkg::PH_DATA) begin
      so <= tx_r[7];
    end
  end

  // The output is driven only during the data phase of a valid read.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= cs_low && phase_r == sfdp_pkg::PH_DATA;
    end
  end

  // --------------------------------------------------------------------------
  // Status
  // --------------------------------------------------------------------------

  // Busy marks a frame that has passed the opcode check.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      table_busy <= 1'b0;
    end else begin
      table_busy <= cs_low && (phase_r == sfdp_pkg::PH_ADDR ||
                               phase_r == sfdp_pkg::PH_DUMMY ||
                               phase_r == sfdp_pkg::PH_DATA);
    end
  end

  // Reject stands while a frame with any other opcode is being ignored.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reject <= 1'b0;
    end else begin
      cmd_reject <= cs_low && phase_r == sfdp_pkg::PH_IGNORE;
    end
  end

endmodule : sfdp_reader

// file: hw/sfdp_params.svh
// Constants for the discoverable parameter table read path.
`ifndef SFDP_PARAMS_SVH
`define SFDP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Link command and frame layout
// ----------------------------------------------------------------------------
`define SFDP_READ_OPCODE     8'h5A
`define SFDP_ADDR_BITS       24
`define SFDP_DUMMY_CLKS      8
`define SFDP_BYTE_BITS       8
`define SFDP_ERASED_BYTE     8'hFF

// ----------------------------------------------------------------------------
// Parameter header that points at the basic table
// ----------------------------------------------------------------------------
`define SFDP_HDR_ID_ADDR     24'h000008
`define SFDP_HDR_MINOR_ADDR  24'h000009
`define SFDP_HDR_MAJOR_ADDR  24'h00000A
`define SFDP_HDR_LEN_ADDR    24'h00000B
`define SFDP_HDR_PTR0_ADDR   24'h00000C
`define SFDP_HDR_PTR1_ADDR   24'h00000D
`define SFDP_HDR_PTR2_ADDR   24'h00000E
`define SFDP_HDR_ID          8'h00
`define SFDP_HDR_MINOR       8'h00
`define SFDP_HDR_MAJOR       8'h01
`define SFDP_BASIC_LEN_DW    8'h09
`define SFDP_BASIC_BASE      24'h000030

// ----------------------------------------------------------------------------
// Basic table fields
// ----------------------------------------------------------------------------
`define SFDP_ERASE_4K_CODE   2'b01
`define SFDP_WR_GRAN_64B     1'b1
`define SFDP_VOL_WREN_REQ    1'b0
`define SFDP_VOL_WREN_SEL    1'b0
`define SFDP_UNUSED3         3'h7
`define SFDP_ERASE_4K_OP     8'h20
`define SFDP_ADDR_3B_ONLY    2'b00
`define SFDP_DTR_SUPPORT     1'b0
`define SFDP_DENSITY_BITS_M1 32'h03FFFFFF
`define SFDP_Q144_WAIT       5'h04
`define SFDP_Q144_MODE       3'h2
`define SFDP_Q144_OP         8'hEB
`define SFDP_Q114_WAIT       5'h08
`define SFDP_Q114_MODE       3'h0
`define SFDP_Q114_OP         8'h6B
`define SFDP_D112_WAIT       5'h08
`define SFDP_D112_MODE       3'h0
`define SFDP_D112_OP         8'h3B
`define SFDP_D122_WAIT       5'h02
`define SFDP_D122_MODE       3'h2
`define SFDP_D122_OP         8'hBB
`define SFDP_NONE_WAIT       5'h00
`define SFDP_NONE_MODE       3'h0
`define SFDP_NONE_OP         8'hFF
`define SFDP_ERASE1_EXP      8'h0C
`define SFDP_ERASE1_OP       8'h20
`define SFDP_ERASE2_EXP      8'h0F
`define SFDP_ERASE2_OP       8'h52
`define SFDP_ERASE3_EXP      8'h10
`define SFDP_ERASE3_OP       8'hD8
`define SFDP_ERASE4_EXP      8'h00
`define SFDP_ERASE4_OP       8'hFF

`endif

// file: hw/sfdp_pkg.sv
// Types shared by the parameter table read path.
package sfdp_pkg;

  // Frame phases, Gray coded along command, address, dummy, data.
  typedef enum logic [2:0] {
    PH_CMD    = 3'h0,
    PH_ADDR   = 3'h1,
    PH_DUMMY  = 3'h3,
    PH_DATA   = 3'h2,
    PH_IGNORE = 3'h6
  } phase_t;

endpackage : sfdp_pkg

// file: hw/sfdp_basic_table_rom.sv
// Read-only contents of the parameter header and the basic parameter table.
`timescale 1ns/10ps
`include "sfdp_params.svh"

module sfdp_basic_table_rom (
  // Byte lookup
  input  wire logic [23:0] addr,
  output logic      [7:0]  data
);

  // Bytes are assembled from their fields; 0DH, 0EH and some bits of 32H and 40H are plain literals.
  always_comb begin
    case (addr)
      `SFDP_HDR_ID_ADDR:    data = `SFDP_HDR_ID;
      `SFDP_HDR_MINOR_ADDR: data = `SFDP_HDR_MINOR;
      `SFDP_HDR_MAJOR_ADDR: data = `SFDP_HDR_MAJOR;
      `SFDP_HDR_LEN_ADDR:   data = `SFDP_BASIC_LEN_DW;
      `SFDP_HDR_PTR0_ADDR:  data = 8'(`SFDP_BASIC_BASE);
      `SFDP_HDR_PTR1_ADDR:  data = 8'h00;
      `SFDP_HDR_PTR2_ADDR:  data = 8'h00;
      24'h000030: data = {`SFDP_UNUSED3, `SFDP_VOL_WREN_SEL, `SFDP_VOL_WREN_REQ,
                          `SFDP_WR_GRAN_64B, `SFDP_ERASE_4K_CODE};
      24'h000031: data = `SFDP_ERASE_4K_OP;
      24'h000032: data = {1'b1, 1'b1, 1'b1, 1'b1, `SFDP_DTR_SUPPORT,
                          `SFDP_ADDR_3B_ONLY, 1'b1};
      24'h000034: data = 8'(`SFDP_DENSITY_BITS_M1);
      24'h000035: data = 8'(`SFDP_DENSITY_BITS_M1 >> 8);
      24'h000036: data = 8'(`SFDP_DENSITY_BITS_M1 >> 16);
      24'h000037: data = 8'(`SFDP_DENSITY_BITS_M1 >> 24);
      24'h000038: data = {`SFDP_Q144_MODE, `SFDP_Q144_WAIT};
      24'h000039: data = `SFDP_Q144_OP;
      24'h00003A: data = {`SFDP_Q114_MODE, `SFDP_Q114_WAIT};
      24'h00003B: data = `SFDP_Q114_OP;
      24'h00003C: data = {`SFDP_D112_MODE, `SFDP_D112_WAIT};
      24'h00003D: data = `SFDP_D112_OP;
      24'h00003E: data = {`SFDP_D122_MODE, `SFDP_D122_WAIT};
      24'h00003F: data = `SFDP_D122_OP;
      24'h000040: data = {`SFDP_UNUSED3, 1'b0, `SFDP_UNUSED3, 1'b0};
      24'h000046: data = {`SFDP_NONE_MODE, `SFDP_NONE_WAIT};
      24'h000047: data = `SFDP_NONE_OP;
      24'h00004A: data = {`SFDP_NONE_MODE, `SFDP_NONE_WAIT};
      24'h00004B: data = `SFDP_NONE_OP;
      24'h00004C: data = `SFDP_ERASE1_EXP;
      24'h00004D: data = `SFDP_ERASE1_OP;
      24'h00004E: data = `SFDP_ERASE2_EXP;
      24'h00004F: data = `SFDP_ERASE2_OP;
      24'h000050: data = `SFDP_ERASE3_EXP;
      24'h000051: data = `SFDP_ERASE3_OP;
      24'h000052: data = `SFDP_ERASE4_EXP;
      24'h000053: data = `SFDP_ERASE4_OP;
      // Unused bytes, including 33H, 41H-45H and 48H-49H, read as ones.
      default:    data = `SFDP_ERASED_BYTE;
    endcase
  end

endmodule : sfdp_basic_table_rom

// file: dv/sfdp_reader_asserts.sv
// Port-level assertions for the parameter table reader.
`timescale 1ns/10ps

module sfdp_reader_asserts #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  // Frame status
  input wire logic table_busy,
  input wire logic cmd_reject
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_reset_quiet;
    $rose(arst_n) |-> so && !so_oe && !table_busy && !cmd_reject;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");

  property p_oe_in_read;
    so_oe |-> table_busy;
  endproperty
  a_oe_in_read: assert property (p_oe_in_read) else $error("output enabled outside a read");

  property p_reject_silent;
    cmd_reject |-> !table_busy && !so_oe;
  endproperty
  a_reject_silent: assert property (p_reject_silent) else $error("refused frame drives data");

  property p_idle_high;
    !so_oe |-> so;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("data line low while released");

  // A gap of six cycles covers the synchroniser plus the output register.
  property p_frame_clear;
    cs_n [*6] |-> !table_busy && !cmd_reject && !so_oe && so;
  endproperty
  a_frame_clear: assert property (p_frame_clear) else $error("frame status left after deselect");

  property p_so_hold;
    (!cs_n && sclk) [*4] |-> $stable(so);
  endproperty
  a_so_hold: assert property (p_so_hold) else $error("data changed while clock high");

  property p_busy_start;
    $rose(table_busy) |-> !$past(cs_n, 3);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("read began without select");

  property p_reject_hold;
    cmd_reject && !cs_n |=> cmd_reject;
  endproperty
  a_reject_hold: assert property (p_reject_hold) else $error("refusal dropped mid frame");

  property p_busy_hold;
    table_busy && !cs_n |=> table_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("read dropped mid frame");
endmodule : sfdp_reader_asserts

bind sfdp_reader sfdp_reader_asserts #(.SYNC_STAGES(SYNC_STAGES)) sfdp_reader_asserts_inst (
  .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
  .so_oe(so_oe), .table_busy(table_busy), .cmd_reject(cmd_reject));

// file: dv/sfdp_host_model.sv
// Behavioural host controller that clocks frames into the reader.
`timescale 1ns/10ps

module sfdp_host_model (
  // Core clock for pacing
  input  wire logic clk,
  // Serial link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  // --------------------------------------------------------------------------
  // Frame engine
  // --------------------------------------------------------------------------
  logic [7:0] rx [0:63];

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // Every pin change lands 2 ns after a core edge so the sampling never races.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  // Mode 0: data set while the clock is low, sampled at the rise.
  task automatic bit_io(input logic b, output logic q);
    si = b;
    tick(5);
    sclk = 1'b1;
    q = so;
    tick(5);
    sclk = 1'b0;
  endtask : bit_io

  // Unused data-in bits toggle so a stale level is never mistaken for data.
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nbits);
    logic [31:0] hdr;
    logic        q;
    hdr = {op, addr};
    cs_n = 1'b0;
    for (int i = 0; i < 32; i++) begin
      bit_io(hdr[31-i], q);
    end
    for (int i = 0; i < 8 + nbits; i++) begin
      bit_io(~si, q);
      if (i >= 8) begin
        rx[(i-8)/8][7-((i-8)%8)] = q;
      end
    end
    tick(5);
    cs_n = 1'b1;
    si = ~si;
    tick(6);
  endtask : frame
endmodule : sfdp_host_model

// file: dv/sfdp_reader_test.sv
// Self-checking bench for the parameter table reader.
`timescale 1ns/10ps

module sfdp_reader_test;
  // --------------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------------
  logic        clk, arst_n, sclk, cs_n, si, so, so_oe, table_busy, cmd_reject;
  logic        oe_seen, rej_seen, busy_seen;
  logic [23:0] base_addr;
  int          bad_count, tests_run, cycles;

  sfdp_reader #(.SYNC_STAGES(2)) sfdp_reader_inst (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .table_busy(table_busy), .cmd_reject(cmd_reject));
  sfdp_host_model sfdp_host_model_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Status is watched every cycle since refusal shows no data at all.
  always @(posedge clk) begin
    if (so_oe === 1'b1) oe_seen = 1'b1;
    if (cmd_reject === 1'b1) rej_seen = 1'b1;
    if (table_busy === 1'b1) busy_seen = 1'b1;
  end

  // The run needs about 9400 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED timeout expected 0 seen %0d", cycles);
      wrap_up();
    end
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_byte(name, {7'h00, exp}, {7'h00, got});
  endtask : check_bit

  // Dword values are given as numbers; the link must deliver the low byte first.
  task automatic chk_dw(input logic [23:0] a, input logic [31:0] exp);
    for (int i = 0; i < 4; i++) begin
      check_byte($sformatf("byte %h", a + i), exp[8*i +: 8], sfdp_host_model_inst.rx[a - base_addr + i]);
    end
  endtask : chk_dw

  task automatic run_frame(input logic [7:0] op, input logic [23:0] addr, input int nbits);
    base_addr = addr;
    oe_seen   = 1'b0;
    rej_seen  = 1'b0;
    busy_seen = 1'b0;
    sfdp_host_model_inst.frame(op, addr, nbits);
  endtask : run_frame

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_basic_table;
    run_frame(8'h5A, 24'h000030, 38 * 8);
    check_bit("read enable seen", 1'b1, oe_seen);
    chk_dw(24'h30, 32'hFFF120E5);
    chk_dw(24'h34, 32'h03FFFFFF);
    chk_dw(24'h38, 32'h6B08EB44);
    chk_dw(24'h3C, 32'hBB423B08);
    chk_dw(24'h40, 32'hFFFFFFEE);
    chk_dw(24'h44, 32'hFF00FFFF);
    chk_dw(24'h48, 32'hFF00FFFF);
    chk_dw(24'h4C, 32'h520F200C);
    chk_dw(24'h50, 32'hFF00D810);
    check_byte("byte 54", 8'hFF, sfdp_host_model_inst.rx[36]);
    $display("t_basic_table done");
  endtask : t_basic_table

  task automatic t_header;
    run_frame(8'h5A, 24'h000008, 64);
    chk_dw(24'h08, 32'h09010000);
    chk_dw(24'h0C, 32'hFF000030);
    $display("t_header done");
  endtask : t_header

  task automatic t_reject;
    logic [7:0] ops [3];
    ops = '{8'h03, 8'h0B, 8'h02};
    foreach (ops[i]) begin
      run_frame(ops[i], 24'h000030, 16);
      check_bit("refusal seen", 1'b1, rej_seen);
      check_bit("refused enable", 1'b0, oe_seen);
      check_bit("refused busy", 1'b0, busy_seen);
    end
    run_frame(8'h5A, 24'h000030, 32);
    check_bit("read refused", 1'b0, rej_seen);
    chk_dw(24'h30, 32'hFFF120E5);
    $display("t_reject done");
  endtask : t_reject

  task automatic t_order;
    run_frame(8'h5A, 24'h000030, 3);
    run_frame(8'h5A, 24'h000031, 8);
    check_byte("after abort", 8'h20, sfdp_host_model_inst.rx[0]);
    run_frame(8'h5A, 24'h00002E, 32);
    chk_dw(24'h2E, 32'h20E5FFFF);
    run_frame(8'h5A, 24'h000052, 32);
    chk_dw(24'h52, 32'hFFFFFF00);
    check_bit("busy cleared", 1'b0, table_busy);
    check_bit("enable cleared", 1'b0, so_oe);
    check_bit("line released", 1'b1, so);
    $display("t_order done");
  endtask : t_order

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    arst_n    = 1'b0;
    bad_count = 0;
    tests_run = 0;
    cycles    = 0;
    repeat (3) @(posedge clk);
    #2 arst_n = 1'b1;
    repeat (5) @(posedge clk);
    #2;
    t_basic_table();
    t_header();
    t_reject();
    t_order();
    wrap_up();
  end
endmodule : sfdp_reader_test
